// *** logic/mss_top.sv ***
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module mss_top (
  // Clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output wire logic [31:0] PRDATA_O,
  output wire logic        PREADY_O,
  output wire logic        PSLVERR_O,
  // Memory map state
  output wire logic [16:0] ROM_LIMIT_O,
  output wire logic        EXP_RAM_EN_O
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]  mem_size_ff;
  logic [7:0]  nxt_mem_size;
  logic [7:0]  exp_ram_size_ff;
  logic [7:0]  nxt_exp_ram_size;
  logic [15:0] probe_ff;
  logic [15:0] nxt_probe;
  logic        bad_wr_ff;
  logic        nxt_bad_wr;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        rom_hit;
  logic        exp_hit;

  mss_dec_if dec ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic acc      = PSEL_I && PENABLE_I;
  wire logic wr       = acc && PWRITE_I;
  wire logic sel_mem  = PADDR_I == mss_pkg::MEM_SIZE_OFFS;
  wire logic sel_exp  = PADDR_I == mss_pkg::EXP_RAM_SIZE_OFFS;
  wire logic sel_stat = PADDR_I == mss_pkg::STATUS_OFFS;
  wire logic sel_chk  = PADDR_I == mss_pkg::ADDR_CHECK_OFFS;
  wire logic mapped   = sel_mem || sel_exp || sel_stat || sel_chk;
  wire logic [7:0] wb = PWDATA_I[7:0];

  // Single wait-free answer; unmapped addresses flag an error
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = acc && !mapped;

  // ----------------------------------------------------------------
  // Write acceptance
  // ----------------------------------------------------------------
  // ROM code check
  wire logic rom_ok = (wb[3:0] == mss_pkg::ROM_CODE_24K) || (wb[3:0] == mss_pkg::ROM_CODE_32K)
                   || (wb[3:0] == mss_pkg::ROM_CODE_40K) || (wb[3:0] == mss_pkg::ROM_CODE_48K)
                   || (wb[3:0] == mss_pkg::ROM_CODE_56K) || (wb[3:0] == mss_pkg::ROM_CODE_60K);
  wire logic ram_ok = (wb[7:5] == mss_pkg::HSRAM_CODE_1K) && !wb[4];
  // Prohibited codes are dropped so the map never reaches an undefined size
  wire logic mem_we = wr && sel_mem && PSTRB_I[0] && rom_ok && ram_ok;
  wire logic exp_ok = (wb == mss_pkg::EXP_RAM_CODE_FULL) || (wb == mss_pkg::EXP_RAM_CODE_NONE);
  wire logic exp_we = wr && sel_exp && PSTRB_I[0] && exp_ok;
  wire logic mem_bad = wr && sel_mem && !(PSTRB_I[0] && rom_ok && ram_ok);
  wire logic exp_bad = wr && sel_exp && !(PSTRB_I[0] && exp_ok);

  // Next values
  assign nxt_mem_size     = mem_we ? wb : mem_size_ff;
  assign nxt_exp_ram_size = exp_we ? wb : exp_ram_size_ff;
  assign nxt_probe        = (wr && sel_chk && PSTRB_I[0] && PSTRB_I[1]) ? PWDATA_I[15:0]
                                                                        : probe_ff;
  // Sticky until the status register is written
  assign nxt_bad_wr       = (mem_bad || exp_bad) ? 1'b1 : ((wr && sel_stat) ? 1'b0 : bad_wr_ff);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // read back
  wire logic [31:0] rd_mem  = {24'h000000, mem_size_ff};
  wire logic [31:0] rd_exp  = {24'h000000, exp_ram_size_ff};
  wire logic [31:0] rd_stat = {29'h00000000, bad_wr_ff, dec.exp_ram_en, dec.rom_code_ok};
  wire logic [31:0] rd_chk  = {14'h0000, exp_hit, rom_hit, probe_ff};
  assign nxt_rdata = (!PSEL_I || PENABLE_I || PWRITE_I) ? rdata_ff :
                     sel_mem  ? rd_mem  :
                     sel_exp  ? rd_exp  :
                     sel_stat ? rd_stat :
                     sel_chk  ? rd_chk  : 32'h00000000;
  assign PRDATA_O = rdata_ff;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  // reset CFH for memory size, 0AH for expansion RAM size, zero for the rest
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mem_size_ff     <= mss_pkg::MEM_SIZE_RST;
      exp_ram_size_ff <= mss_pkg::EXP_RAM_SIZE_RST;
      probe_ff        <= 16'h0000;
      bad_wr_ff       <= 1'b0;
      rdata_ff        <= 32'h00000000;
    end else begin
      mem_size_ff     <= nxt_mem_size;
      exp_ram_size_ff <= nxt_exp_ram_size;
      probe_ff        <= nxt_probe;
      bad_wr_ff       <= nxt_bad_wr;
      rdata_ff        <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Size decode
  // ----------------------------------------------------------------
  wire logic [3:0] rom_code = mem_size_ff[mss_pkg::ROM_FIELD_MSB:mss_pkg::ROM_FIELD_LSB];
  assign dec.rom_limit =
    (rom_code == mss_pkg::ROM_CODE_24K) ? mss_pkg::ROM_LIMIT_24K :
    (rom_code == mss_pkg::ROM_CODE_32K) ? mss_pkg::ROM_LIMIT_32K :
    (rom_code == mss_pkg::ROM_CODE_40K) ? mss_pkg::ROM_LIMIT_40K :
    (rom_code == mss_pkg::ROM_CODE_48K) ? mss_pkg::ROM_LIMIT_48K :
    (rom_code == mss_pkg::ROM_CODE_56K) ? mss_pkg::ROM_LIMIT_56K : mss_pkg::ROM_LIMIT_60K;
  assign dec.rom_code_ok = mem_size_ff[mss_pkg::HSRAM_FIELD_MSB:mss_pkg::HSRAM_FIELD_LSB]
                           == mss_pkg::HSRAM_CODE_1K;
  assign dec.exp_ram_en = exp_ram_size_ff != mss_pkg::EXP_RAM_CODE_NONE;

  assign ROM_LIMIT_O  = dec.rom_limit;
  assign EXP_RAM_EN_O = dec.exp_ram_en;

  // ----------------------------------------------------------------
  // Window check on the probe address
  // ----------------------------------------------------------------
  mss_window u_window (
    .dec           (dec.check),
    .addr_i        (probe_ff),
    .rom_hit_o     (rom_hit),
    .exp_ram_hit_o (exp_hit)
  );
endmodule

// *** logic/mss_pkg.sv ***
package mss_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] MEM_SIZE_OFFS     = 8'h00;
  localparam logic [7:0] EXP_RAM_SIZE_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS       = 8'h08;
  localparam logic [7:0] ADDR_CHECK_OFFS   = 8'h0c;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] MEM_SIZE_RST      = 8'hcf;
  localparam logic [7:0] EXP_RAM_SIZE_RST  = 8'h0a;
  localparam int         ROM_FIELD_LSB     = 0;
  localparam int         ROM_FIELD_MSB     = 3;
  localparam int         HSRAM_FIELD_LSB   = 5;
  localparam int         HSRAM_FIELD_MSB   = 7;
  localparam logic [2:0] HSRAM_CODE_1K     = 3'h6;

  // ----------------------------------------------------------------
  // Capacity codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ROM_CODE_24K      = 4'h6;
  localparam logic [3:0] ROM_CODE_32K      = 4'h8;
  localparam logic [3:0] ROM_CODE_40K      = 4'ha;
  localparam logic [3:0] ROM_CODE_48K      = 4'hc;
  localparam logic [3:0] ROM_CODE_56K      = 4'he;
  localparam logic [3:0] ROM_CODE_60K      = 4'hf;
  localparam logic [7:0] EXP_RAM_CODE_FULL = 8'h0a;
  localparam logic [7:0] EXP_RAM_CODE_NONE = 8'h0c;

  // ROM limits in bytes (first byte beyond the ROM)
  localparam logic [16:0] ROM_LIMIT_24K    = 17'h06000;
  localparam logic [16:0] ROM_LIMIT_32K    = 17'h08000;
  localparam logic [16:0] ROM_LIMIT_40K    = 17'h0a000;
  localparam logic [16:0] ROM_LIMIT_48K    = 17'h0c000;
  localparam logic [16:0] ROM_LIMIT_56K    = 17'h0e000;
  localparam logic [16:0] ROM_LIMIT_60K    = 17'h0f000;
  localparam logic [10:0] EXP_RAM_BYTES    = 11'h400;
endpackage

// *** logic/mss_dec_if.sv ***
`timescale 1ns/100ps
// Decoded sizes passed from the register bank to the window check
interface mss_dec_if;
  logic [16:0] rom_limit;
  logic        exp_ram_en;
  logic        rom_code_ok;
  modport bank  (output rom_limit, output exp_ram_en, output rom_code_ok);
  modport check (input rom_limit, input exp_ram_en);
endinterface

// *** logic/mss_window.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Address window check for ROM and expansion RAM
// ------------------------------------------------------------------
module mss_window #(
  parameter logic [15:0] EXP_RAM_BASE = 16'hf000
) (
  // Size information
  mss_dec_if.check    dec,
  // Probe address
  input  wire logic [15:0] addr_i,
  output wire logic        rom_hit_o,
  output wire logic        exp_ram_hit_o
);
  wire logic [16:0] addr_ext = {1'b0, addr_i};
  wire logic [16:0] exp_top  = {1'b0, EXP_RAM_BASE} + {6'h00, mss_pkg::EXP_RAM_BYTES};

  assign rom_hit_o     = addr_ext < dec.rom_limit;
  assign exp_ram_hit_o = dec.exp_ram_en && (addr_ext >= {1'b0, EXP_RAM_BASE})
                         && (addr_ext < exp_top);
endmodule

// *** dv/mss_asserts.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Register bank and memory map checks
// ------------------------------------------------------------------
module mss_chk (
  // Clock and reset
  input wire logic        REF_CLK_I,
  input wire logic        RST_N_I,
  // APB side
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0]  PSTRB_I,
  input wire logic        PSLVERR_O,
  // Map state
  input wire logic [16:0] ROM_LIMIT_O,
  input wire logic        EXP_RAM_EN_O
);
  // Completed byte writes per register
  wire       wr_ok  = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
  wire       wr_mem = wr_ok & (PADDR_I == 8'h00);
  wire       wr_exp = wr_ok & (PADDR_I == 8'h04);
  wire [7:0] wd     = PWDATA_I[7:0];
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_rst_rom: assert property ($rose(RST_N_I) |-> ROM_LIMIT_O == 17'h0f000)
    else $error("rom limit wrong after reset");
  chk_rst_exp: assert property ($rose(RST_N_I) |-> EXP_RAM_EN_O)
    else $error("expansion ram missing after reset");
  chk_exp_none: assert property (wr_exp && wd == 8'h0c |=> !EXP_RAM_EN_O)
    else $error("expansion ram still mapped");
  chk_exp_full: assert property (wr_exp && wd == 8'h0a |=> EXP_RAM_EN_O)
    else $error("expansion ram not mapped");
  chk_exp_hold: assert property (wr_exp && wd != 8'h0a && wd != 8'h0c |=> $stable(EXP_RAM_EN_O))
    else $error("bad expansion code changed map");
  chk_rom_24k: assert property (wr_mem && wd == 8'hc6 |=> ROM_LIMIT_O == 17'h06000)
    else $error("rom limit not 24k");
  chk_rom_56k: assert property (wr_mem && wd == 8'hce |=> ROM_LIMIT_O == 17'h0e000)
    else $error("rom limit not 56k");
  chk_rom_bad: assert property (wr_mem && wd[7:4] != 4'hc |=> $stable(ROM_LIMIT_O))
    else $error("bad high nibble changed map");
  chk_map_hold: assert property (!wr_mem |=> $stable(ROM_LIMIT_O))
    else $error("rom limit moved without write");
  chk_err_unmap: assert property (PSEL_I && PENABLE_I && PADDR_I > 8'h0c |-> PSLVERR_O)
    else $error("unmapped access without error");
endmodule
bind mss_top mss_chk mss_chk_i (.REF_CLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PWDATA_I, .PSTRB_I, .PSLVERR_O, .ROM_LIMIT_O, .EXP_RAM_EN_O);

// *** dv/memory_size_switching_tb.sv ***
`timescale 1ns/100ps
module memory_size_switching_tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [16:0] rom_lim;
  wire         exp_en;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [7:0]  mem_m;
  logic [7:0]  d;
  logic [3:0]  codes[6] = '{4'h6, 4'h8, 4'ha, 4'hc, 4'he, 4'hf};
  int          num_errors = 0;
  int          total_checks = 0;
  mss_top mss_top_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .ROM_LIMIT_O(rom_lim), .EXP_RAM_EN_O(exp_en));
  always #25 clk = ~clk;
  // ----------------------------------------------------------------
  // Read monitor: oldest note is matched at the access edge
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      exp_v = exp_q.pop_front();
      total_checks++;
      if (prdata !== exp_v) begin
        num_errors++;
        $display("wrong value at %0t: read %h expected %h", $time, prdata, exp_v);
      end
      if (paddr == 8'h10) begin
        total_checks++;
        if (pslverr !== 1'b1) begin
          num_errors++;
          $display("wrong value at %0t: no error on unmapped read", $time);
        end
      end
    end
  end
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One APB transfer; the wait is bounded so a dead slave cannot hang us
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                     input logic [3:0] s, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    pstrb <= s;
    if (!w) exp_q.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(11));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 8'h00, 4'hf, 8'hcf);
    apb(1'b0, 8'h04, 8'h00, 4'hf, 8'h0a);
    foreach (codes[i]) begin
      apb(1'b1, 8'h00, {4'hc, codes[i]}, 4'hf, 8'h00);
      apb(1'b0, 8'h00, 8'h00, 4'hf, {4'hc, codes[i]});
    end
    mem_m = 8'hcf;
    // Random bytes, half steered to a legal high nibble so both paths run
    repeat (12) begin
      d = 8'($urandom);
      if (d[0]) d[7:4] = 4'hc;
      apb(1'b1, 8'h00, d, 4'hf, 8'h00);
      if (d[7:4] == 4'hc && d[3:0] inside {codes}) mem_m = d;
      apb(1'b0, 8'h00, 8'h00, 4'hf, mem_m);
    end
    apb(1'b1, 8'h00, 8'hc6, 4'he, 8'h00);
    apb(1'b0, 8'h00, 8'h00, 4'hf, mem_m);
    apb(1'b1, 8'h04, 8'h0c, 4'hf, 8'h00);
    apb(1'b0, 8'h04, 8'h00, 4'hf, 8'h0c);
    apb(1'b1, 8'h04, 8'h05, 4'hf, 8'h00);
    apb(1'b0, 8'h04, 8'h00, 4'hf, 8'h0c);
    apb(1'b0, 8'h08, 32'h0, 4'hf, 32'h5);
    apb(1'b1, 8'h04, 8'h0a, 4'hf, 8'h00);
    apb(1'b0, 8'h04, 8'h00, 4'hf, 8'h0a);
    // Clear the sticky flag, then a legal 56K ROM size setting
    apb(1'b1, 8'h08, 32'h0, 4'hf, 32'h0);
    apb(1'b1, 8'h00, 32'hce, 4'hf, 32'h0);
    apb(1'b0, 8'h08, 32'h0, 4'hf, 32'h3);
    total_checks++;
    if (rom_lim !== 17'h0e000 || exp_en !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: map state after 56k write", $time);
    end
    // Probe one address in expansion RAM and one in ROM
    apb(1'b1, 8'h0c, 32'hf010, 4'hf, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, 4'hf, 32'h0002f010);
    apb(1'b1, 8'h0c, 32'h1000, 4'hf, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, 4'hf, 32'h00011000);
    apb(1'b0, 8'h10, 8'h00, 4'hf, 8'h00);
    apb(1'b1, 8'h00, 8'hc8, 4'hf, 8'h00);
    apb(1'b1, 8'h04, 8'h0c, 4'hf, 8'h00);
    // Reset again in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 8'h00, 4'hf, 8'hcf);
    apb(1'b0, 8'h04, 8'h00, 4'hf, 8'h0a);
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule
